// [inc/keyport_params.svh]
/*
  Constants for the key matrix port block: register offsets, field
  positions, reset values, option byte codes and the interval timing.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef KEYPORT_PARAMS_SVH
`define KEYPORT_PARAMS_SVH

// register byte offsets on the avalon slave
`define KP_OFF_DIR 5'h00
`define KP_OFF_PULLUP 5'h04
`define KP_OFF_DETECT 5'h08
`define KP_OFF_CTRL 5'h0C
`define KP_OFF_STATUS 5'h10
`define KP_OFF_SAMPLE 5'h14
`define KP_OFF_OUT 5'h18
`define KP_OFF_OPTION 5'h1C

// reset values
`define KP_DIR_RST 8'hFF
`define KP_PULLUP_RST 8'h00
`define KP_DETECT_RST 8'h00
`define KP_OUT_RST 8'h00
`define KP_SCAN_RST 4'hF

// control and status field positions
`define KP_CTRL_LOW_BIT 0
`define KP_CTRL_HIGH_BIT 1
`define KP_CTRL_RUN_BIT 2
`define KP_CTRL_SCAN_LSB 4
`define KP_ST_TICK_BIT 0
`define KP_ST_KEY_BIT 1
`define KP_ST_PIN_LSB 8

// option byte codes
`define KP_OPT_WDT_STOP 8'h6E
`define KP_OPT_HS_32M 8'hE8
`define KP_OPT_DEBUG_ON 8'h84

// key detection spacing
`define KP_INTERVAL_MS 30
`define KP_CLK_HZ 25000000
`define KP_INTERVAL_CYC ((`KP_CLK_HZ / 1000) * `KP_INTERVAL_MS)

`endif

// [inc/keyport_pkg.sv]
/*
  Types for the key matrix port block.
  Assumes keyport_params.svh on the include path.
*/
`include "keyport_params.svh"

package keyport_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;
endpackage : keyport_pkg

// [inc/keyport_if.sv]
/*
  Carrier between the port block and its interval timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface keyport_if;
  logic run;
  logic tick;
  modport timer (input run, output tick);
  modport user (output run, input tick);
endinterface : keyport_if

`default_nettype wire

// [rtl/keyport_interval.sv]
/*
  Interval timer that paces key detections.
  Assumes run comes from a register on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

`include "keyport_params.svh"

module keyport_interval
  import keyport_pkg::*;
#(
  parameter int unsigned CYCLES = `KP_INTERVAL_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  keyport_if.timer link
);
  localparam logic [19:0] LAST = 20'(CYCLES - 1);

  logic [19:0] cnt;
  logic [19:0] next_cnt;
  logic tick;
  logic next_tick;

  // count a full interval while running, pulse at its end
  always_comb begin
    next_cnt = 20'h00000;
    next_tick = 1'b0;
    if (link.run) begin
      if (cnt == LAST) begin
        next_tick = 1'b1; // RULE6
      end else begin
        next_cnt = cnt + 20'h00001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 20'h00000;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

  assign link.tick = tick;

  // a tick only ever closes a full interval of running
  tick_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
    tick |-> $past(cnt) == LAST && $past(link.run) && cnt == 20'h00000)
    else $error("interval tick without a full count");

endmodule : keyport_interval

`default_nettype wire

// [rtl/keyport_top.sv]
/*
  Key matrix port block: port seven direction, pull-up, key-return
  detection, scan lines, paced key sampling and boot option bytes.
  Assumes an avalon-mm master on REF_CLK_I, and pins and option
  straps that are asynchronous to it.
*/
`timescale 1ns/1ps
`default_nettype none

`include "keyport_params.svh"

//////////////////////////////////////////////////////////////////////
// Contract
// RULE1: direction bit 0 drives the pin, 1 makes it an input.
// RULE2: pull-up bit 1 connects the pin pull-up, 0 leaves it off.
// RULE3: software sets pull-up bits 0..3 wherever key-return detection is on.
// RULE4: software makes return pins inputs with pull-ups before waiting for keys.
// RULE5: one command drives all scan lines low, another all high.
// RULE6: key detections are 30 ms apart, paced by the interval timer.
// RULE7: first option byte 01101110B keeps the watchdog stopped after reset.
// RULE8: third option byte 11101000B starts high-speed mode at 32 MHz.
// RULE9: fourth option byte 10000100B enables the debug interface.
// RULE10: detect bit 1 watches its pin for key presses, 0 ignores it.
// RULE11: option bytes are taken once at reset release and held.
module keyport_top
  import keyport_pkg::*;
#(
  parameter int unsigned INTERVAL_CYCLES = `KP_INTERVAL_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic SRST_I,
  input wire logic [4:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic [7:0] P7_IN_I,
  output logic [7:0] P7_OUT_O,
  output logic [7:0] P7_OE_N_O,
  output logic [7:0] P7_PULLUP_O,
  output logic [3:0] SCAN_O,
  input wire logic [31:0] OPTION_BYTES_I,
  output logic WDT_STOP_O,
  output logic HS_MODE_O,
  output logic FAST_OSC_32M_O,
  output logic DEBUG_EN_O
);

  //////////////////////////////////////////////////////////////////////
  // declarations

  keyport_if tmr_if ();

  bus_state_t state;
  bus_state_t next_state;
  byte_t port_seven_direction;
  byte_t next_port_seven_direction;
  byte_t port_seven_pullup;
  byte_t next_port_seven_pullup;
  byte_t key_return_detect_bits;
  byte_t next_key_return_detect_bits;
  byte_t out_data;
  byte_t next_out_data;
  byte_t sample;
  byte_t next_sample;
  logic [3:0] scan;
  logic [3:0] next_scan;
  logic run;
  logic next_run;
  logic tick_flag;
  logic next_tick_flag;
  logic waitreq;
  logic next_waitreq;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [31:0] rd_mux;
  logic wr_ok;
  logic key_seen;
  byte_t pressed;

  byte_t pin_meta;
  byte_t pin_sync;
  logic [31:0] opt_meta;
  logic [31:0] opt_sync;

  logic opt_taken;
  logic next_opt_taken;
  logic [31:0] opt_hold;
  logic [31:0] next_opt_hold;
  logic wdt_stop;
  logic next_wdt_stop;
  logic hs_mode;
  logic next_hs_mode;
  logic dbg_en;
  logic next_dbg_en;

  // address match used by read and write decode
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
    hit = (addr == off);
  endfunction : hit

  //////////////////////////////////////////////////////////////////////
  // input synchronisers

  // port pins pass two flops before use
  always_ff @(posedge REF_CLK_I) begin
    pin_meta <= P7_IN_I;
    pin_sync <= pin_meta;
  end

  // option straps, one two-flop stage per byte
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_opt_sync
      always_ff @(posedge REF_CLK_I) begin
        opt_meta[8*gi +: 8] <= OPTION_BYTES_I[8*gi +: 8];
        opt_sync[8*gi +: 8] <= opt_meta[8*gi +: 8];
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // interval timer

  assign tmr_if.run = run;

  keyport_interval #(
    .CYCLES(INTERVAL_CYCLES)
  ) u_interval (
    .clk_i(REF_CLK_I),
    .rst_i(SRST_I),
    .link(tmr_if)
  );

  //////////////////////////////////////////////////////////////////////
  // key detection and read mux

  // pressed keys pull low; only enabled return pins count
  assign pressed = key_return_detect_bits & ~pin_sync; // RULE10
  assign key_seen = |pressed;
  assign wr_ok = (state == BUS_ANSWER) && AVS_WRITE_I && AVS_BYTEENABLE_I[0];

  // read data for the addressed register, zero when unmapped
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit(AVS_ADDRESS_I, `KP_OFF_DIR)) begin
      rd_mux[7:0] = port_seven_direction;
    end else if (hit(AVS_ADDRESS_I, `KP_OFF_PULLUP)) begin
      rd_mux[7:0] = port_seven_pullup;
    end else if (hit(AVS_ADDRESS_I, `KP_OFF_DETECT)) begin
      rd_mux[7:0] = key_return_detect_bits;
    end else if (hit(AVS_ADDRESS_I, `KP_OFF_CTRL)) begin
      rd_mux[`KP_CTRL_RUN_BIT] = run;
      rd_mux[`KP_CTRL_SCAN_LSB +: 4] = scan;
    end else if (hit(AVS_ADDRESS_I, `KP_OFF_STATUS)) begin
      rd_mux[`KP_ST_TICK_BIT] = tick_flag;
      rd_mux[`KP_ST_KEY_BIT] = key_seen;
      rd_mux[`KP_ST_PIN_LSB +: 8] = pin_sync;
    end else if (hit(AVS_ADDRESS_I, `KP_OFF_SAMPLE)) begin
      rd_mux[7:0] = sample;
    end else if (hit(AVS_ADDRESS_I, `KP_OFF_OUT)) begin
      rd_mux[7:0] = out_data;
    end else if (hit(AVS_ADDRESS_I, `KP_OFF_OPTION)) begin
      rd_mux = opt_hold;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // bus slave and port registers

  // one wait cycle, then the answer; writes land at the answer edge
  always_comb begin
    next_state = state;
    next_waitreq = waitreq;
    next_rdata = rdata;
    next_port_seven_direction = port_seven_direction;
    next_port_seven_pullup = port_seven_pullup;
    next_key_return_detect_bits = key_return_detect_bits;
    next_out_data = out_data;
    next_scan = scan;
    next_run = run;
    next_tick_flag = tick_flag;
    next_sample = sample;
    case (state)
      BUS_IDLE: begin
        if (AVS_READ_I || AVS_WRITE_I) begin
          next_state = BUS_ANSWER;
          next_waitreq = 1'b0;
          next_rdata = rd_mux;
        end
      end
      BUS_ANSWER: begin
        next_state = BUS_IDLE;
        next_waitreq = 1'b1;
      end
      default: begin
        next_state = BUS_IDLE;
        next_waitreq = 1'b1;
      end
    endcase
    if (wr_ok) begin
      if (hit(AVS_ADDRESS_I, `KP_OFF_DIR)) begin
        next_port_seven_direction = AVS_WRITEDATA_I[7:0]; // RULE1
      end else if (hit(AVS_ADDRESS_I, `KP_OFF_PULLUP)) begin
        next_port_seven_pullup = AVS_WRITEDATA_I[7:0]; // RULE2
      end else if (hit(AVS_ADDRESS_I, `KP_OFF_DETECT)) begin
        next_key_return_detect_bits = AVS_WRITEDATA_I[7:0];
      end else if (hit(AVS_ADDRESS_I, `KP_OFF_OUT)) begin
        next_out_data = AVS_WRITEDATA_I[7:0];
      end else if (hit(AVS_ADDRESS_I, `KP_OFF_CTRL)) begin
        next_run = AVS_WRITEDATA_I[`KP_CTRL_RUN_BIT];
        if (AVS_WRITEDATA_I[`KP_CTRL_LOW_BIT]) begin
          next_scan = 4'h0; // RULE5
        end else if (AVS_WRITEDATA_I[`KP_CTRL_HIGH_BIT]) begin
          next_scan = 4'hF; // RULE5
        end
      end else if (hit(AVS_ADDRESS_I, `KP_OFF_STATUS)) begin
        if (AVS_WRITEDATA_I[`KP_ST_TICK_BIT]) begin
          next_tick_flag = 1'b0;
        end
      end
    end
    // a tick wins over a clear in the same cycle
    if (tmr_if.tick) begin
      next_tick_flag = 1'b1; // RULE6
      next_sample = pressed; // RULE6
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      state <= BUS_IDLE;
      waitreq <= 1'b1;
      rdata <= 32'h00000000;
      port_seven_direction <= `KP_DIR_RST;
      port_seven_pullup <= `KP_PULLUP_RST;
      key_return_detect_bits <= `KP_DETECT_RST;
      out_data <= `KP_OUT_RST;
      scan <= `KP_SCAN_RST;
      run <= 1'b0;
      tick_flag <= 1'b0;
      sample <= 8'h00;
    end else begin
      state <= next_state;
      waitreq <= next_waitreq;
      rdata <= next_rdata;
      port_seven_direction <= next_port_seven_direction;
      port_seven_pullup <= next_port_seven_pullup;
      key_return_detect_bits <= next_key_return_detect_bits;
      out_data <= next_out_data;
      scan <= next_scan;
      run <= next_run;
      tick_flag <= next_tick_flag;
      sample <= next_sample;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // option bytes, taken once after reset release

  always_comb begin
    next_opt_taken = 1'b1;
    next_opt_hold = opt_hold;
    next_wdt_stop = wdt_stop;
    next_hs_mode = hs_mode;
    next_dbg_en = dbg_en;
    if (!opt_taken) begin
      next_opt_hold = opt_sync; // RULE11
      next_wdt_stop = (opt_sync[7:0] == `KP_OPT_WDT_STOP); // RULE7
      next_hs_mode = (opt_sync[23:16] == `KP_OPT_HS_32M); // RULE8
      next_dbg_en = (opt_sync[31:24] == `KP_OPT_DEBUG_ON); // RULE9
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      opt_taken <= 1'b0;
      opt_hold <= 32'h00000000;
      wdt_stop <= 1'b0;
      hs_mode <= 1'b0;
      dbg_en <= 1'b0;
    end else begin
      opt_taken <= next_opt_taken;
      opt_hold <= next_opt_hold;
      wdt_stop <= next_wdt_stop;
      hs_mode <= next_hs_mode;
      dbg_en <= next_dbg_en;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  assign AVS_READDATA_O = rdata;
  assign AVS_WAITREQUEST_O = waitreq;
  assign P7_OUT_O = out_data;
  assign P7_OE_N_O = port_seven_direction; // RULE1
  assign P7_PULLUP_O = port_seven_pullup; // RULE2
  assign SCAN_O = scan;
  assign WDT_STOP_O = wdt_stop;
  assign HS_MODE_O = hs_mode;
  assign FAST_OSC_32M_O = hs_mode;
  assign DEBUG_EN_O = dbg_en;

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);

  direction_write_a: assert property ( // RULE1
    wr_ok && hit(AVS_ADDRESS_I, `KP_OFF_DIR) |=> P7_OE_N_O == $past(AVS_WRITEDATA_I[7:0]))
    else $error("direction write not seen on output enables");

  pullup_write_a: assert property ( // RULE2
    wr_ok && hit(AVS_ADDRESS_I, `KP_OFF_PULLUP) |=> P7_PULLUP_O == $past(AVS_WRITEDATA_I[7:0]))
    else $error("pull-up write not seen on pull-up controls");

  scan_low_a: assert property ( // RULE5
    wr_ok && hit(AVS_ADDRESS_I, `KP_OFF_CTRL) && AVS_WRITEDATA_I[`KP_CTRL_LOW_BIT] |=> SCAN_O == 4'h0)
    else $error("scan lines not all low");

  scan_high_a: assert property ( // RULE5
    wr_ok && hit(AVS_ADDRESS_I, `KP_OFF_CTRL) && !AVS_WRITEDATA_I[`KP_CTRL_LOW_BIT]
    && AVS_WRITEDATA_I[`KP_CTRL_HIGH_BIT] |=> SCAN_O == 4'hF)
    else $error("scan lines not all high");

  sample_pace_a: assert property ( // RULE6
    !tmr_if.tick |=> $stable(sample))
    else $error("key sample changed between ticks");

  detect_mask_a: assert property ( // RULE10
    tmr_if.tick |=> sample == ($past(key_return_detect_bits) & ~$past(pin_sync)))
    else $error("key sample ignores detect enables");

  wdt_option_a: assert property ( // RULE7
    $rose(opt_taken) |-> WDT_STOP_O == (opt_hold[7:0] == `KP_OPT_WDT_STOP))
    else $error("watchdog stop does not follow first option byte");

  hs_option_a: assert property ( // RULE8
    $rose(opt_taken) |-> HS_MODE_O == (opt_hold[23:16] == `KP_OPT_HS_32M) && FAST_OSC_32M_O == HS_MODE_O)
    else $error("high-speed mode does not follow third option byte");

  debug_option_a: assert property ( // RULE9
    $rose(opt_taken) |-> DEBUG_EN_O == (opt_hold[31:24] == `KP_OPT_DEBUG_ON))
    else $error("debug enable does not follow fourth option byte");

  option_hold_a: assert property ( // RULE11
    opt_taken |=> $stable(opt_hold) && $stable(WDT_STOP_O) && $stable(DEBUG_EN_O))
    else $error("option configuration changed after capture");

  bus_answer_a: assert property (
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
    else $error("bus answer not one cycle after request");

endmodule : keyport_top

`default_nettype wire

// [tb/key_matrix.sv]
/*
  Model of the 4x4 key switch matrix hanging on port seven.
  Assumes scan lines drive the columns and pins 0..3 are the return rows;
  key k sits at row k/4, column k%4.
*/
`timescale 1ns/1ps
`default_nettype none

module key_matrix (
  input wire logic clk_i,
  input wire logic [3:0] scan_i,
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_n_i,
  input wire logic [7:0] pullup_i,
  input wire logic [15:0] press_i,
  output logic [7:0] pins_o
);
  logic flip = 1'b0;

  //////////////////////////////////////////////////////////////////////
  // an undriven pin with no pull-up shows a level that changes each cycle
  always @(posedge clk_i) begin
    flip <= ~flip;
  end

  // resolve each pin from its driver, pressed keys and pull-up
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (!oe_n_i[b]) pins_o[b] = out_i[b];
      else if (b < 4 && |(press_i[b*4 +: 4] & ~scan_i)) pins_o[b] = 1'b0;
      else if (pullup_i[b]) pins_o[b] = 1'b1;
      else pins_o[b] = flip ^ b[0];
    end
  end
endmodule : key_matrix

`default_nettype wire

// [tb/keyport_top_tb_top.sv]
/*
  Self-checking bench for the key matrix port block.
  Assumes the key_matrix model on the pins and a short interval count.
*/
`timescale 1ns/1ps
`default_nettype none

`include "keyport_params.svh"

module keyport_top_tb_top;
  import keyport_pkg::*;
  localparam int unsigned IVL = 40;
  typedef struct {string what; logic [31:0] exp;} note_t;
  note_t notes[$];
  note_t nt;
  logic clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, waitreq;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, opt = 32'h84E87F6E, v;
  logic [3:0] be = 4'hF, scan;
  logic [7:0] pins, p_out, p_oe_n, p_pu, dv, ov, det;
  logic [15:0] press = 16'h0;
  logic wdt, hs, osc, dbg;
  int n_fail = 0, n_tests = 0, cyc = 0, seed;

  always #20 clk = ~clk;

  keyport_top #(.INTERVAL_CYCLES(IVL)) keyport_top_i (.REF_CLK_I(clk), .SRST_I(srst),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
    .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .P7_IN_I(pins), .P7_OUT_O(p_out), .P7_OE_N_O(p_oe_n), .P7_PULLUP_O(p_pu), .SCAN_O(scan),
    .OPTION_BYTES_I(opt), .WDT_STOP_O(wdt), .HS_MODE_O(hs), .FAST_OSC_32M_O(osc),
    .DEBUG_EN_O(dbg));

  key_matrix key_matrix_i (.clk_i(clk), .scan_i(scan), .out_i(p_out), .oe_n_i(p_oe_n),
    .pullup_i(p_pu), .press_i(press), .pins_o(pins));

  //////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    rd <= ~w;
    wr <= w;
    // no cycle count assumed here; only the bench timeout ends a hang
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic rd32(input string what, input logic [4:0] a, input logic [31:0] e);
    notes.push_back('{what, e});
    bus(1'b0, a, 32'h0, 4'hF);
  endtask : rd32

  task automatic do_reset;
    @(posedge clk);
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : do_reset

  // expected status word from what the bench set up
  function automatic logic [31:0] st_exp(input logic [7:0] d, o, dt, input logic [3:0] s,
    input logic [15:0] k, input logic t);
    logic [7:0] p;
    for (int b = 0; b < 8; b++) p[b] = !d[b] ? o[b] : !(b < 4 && |(k[b*4 +: 4] & ~s));
    return {16'h0, p, 6'h0, |(dt & ~p), t};
  endfunction : st_exp

  task automatic opt_chk(input logic [31:0] o);
    cmp("wdt_stop", 32'(o[7:0] == 8'h6E), 32'(wdt));
    cmp("hs_mode", 32'(o[23:16] == 8'hE8), 32'(hs));
    cmp("fast_osc", 32'(o[23:16] == 8'hE8), 32'(osc));
    cmp("debug_en", 32'(o[31:24] == 8'h84), 32'(dbg));
  endtask : opt_chk

  //////////////////////////////////////////////////////////////////////
  // take the oldest note whenever read data is answered
  always @(posedge clk) begin
    if (rd && waitreq === 1'b0) begin
      if (notes.size() == 0) cmp("unexpected read", 32'h0, 32'hFFFFFFFF);
      else begin
        nt = notes.pop_front();
        cmp(nt.what, nt.exp, rdata);
      end
    end
  end

  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  // main sequence
  initial begin
    seed = 13;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    cmp("oe_n rst", 32'hFF, 32'(p_oe_n));
    cmp("pullup rst", 32'h00, 32'(p_pu));
    cmp("scan rst", 32'hF, 32'(scan));
    opt_chk(opt);
    rd32("dir rst", `KP_OFF_DIR, 32'hFF);
    rd32("pullup rst", `KP_OFF_PULLUP, 32'h00);
    rd32("detect rst", `KP_OFF_DETECT, 32'h00);
    rd32("ctrl rst", `KP_OFF_CTRL, 32'hF0);
    // exact codes against codes with one bit flipped
    for (int i = 0; i < 8; i++) begin
      v = 32'h84E87F6E;
      if (!i[0]) v[7:0] ^= 8'h01 << ($random(seed) & 7);
      if (!i[1]) v[23:16] ^= 8'h01 << ($random(seed) & 7);
      if (!i[2]) v[31:24] ^= 8'h01 << ($random(seed) & 7);
      opt <= v;
      do_reset();
      opt_chk(v);
      rd32("option", `KP_OFF_OPTION, v);
    end
    opt <= ~v;
    repeat (6) @(posedge clk);
    opt_chk(v);
    rd32("option held", `KP_OFF_OPTION, v);
    bus(1'b1, `KP_OFF_OPTION, 32'h0, 4'hF);
    rd32("option ro", `KP_OFF_OPTION, v);
    // direction and pull-up at the pins, driven levels read back
    for (int i = 0; i < 4; i++) begin
      dv = $random(seed);
      ov = $random(seed);
      bus(1'b1, `KP_OFF_DIR, {24'h0, dv}, 4'hF);
      bus(1'b1, `KP_OFF_PULLUP, {24'h0, ov}, 4'hF);
      @(posedge clk);
      cmp("oe_n", 32'(dv), 32'(p_oe_n));
      cmp("pullup", 32'(ov), 32'(p_pu));
      rd32("dir", `KP_OFF_DIR, {24'h0, dv});
      bus(1'b1, `KP_OFF_PULLUP, 32'hFF, 4'hF);
      bus(1'b1, `KP_OFF_OUT, {24'h0, ov}, 4'hF);
      repeat (4) @(posedge clk);
      cmp("out", 32'(ov), 32'(p_out));
      rd32("status pins", `KP_OFF_STATUS, st_exp(dv, ov, 8'h00, 4'hF, 16'h0, 1'b0));
    end
    bus(1'b1, `KP_OFF_DIR, 32'h00, 4'hE);
    rd32("dir be0", `KP_OFF_DIR, {24'h0, dv});
    rd32("unmapped", 5'h02, 32'h0);
    // scan commands low, high, both (low wins), then none (lines hold)
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `KP_OFF_CTRL, 32'(i + 1) & 32'h3, 4'hF);
      @(posedge clk);
      cmp("scan", (i == 1) ? 32'hF : 32'h0, 32'(scan));
      rd32("ctrl", `KP_OFF_CTRL, (i == 1) ? 32'hF0 : 32'h00);
    end
    // return pins as inputs with pull-ups, every key pressed in turn
    bus(1'b1, `KP_OFF_DIR, 32'h0F, 4'hF);
    bus(1'b1, `KP_OFF_PULLUP, 32'h0F, 4'hF);
    bus(1'b1, `KP_OFF_CTRL, 32'h1, 4'hF);
    for (int k = 0; k < 16; k++) begin
      det = k[0] ? 8'h0F : 8'h0F & ~(8'h01 << (k / 4));
      bus(1'b1, `KP_OFF_DETECT, {24'h0, det}, 4'hF);
      press <= 16'h1 << k;
      repeat (4) @(posedge clk);
      rd32("status key", `KP_OFF_STATUS, st_exp(8'h0F, ov, det, 4'h0, 16'h1 << k, 1'b0));
    end
    // paced detection: tick spacing, sample capture and clear
    press <= 16'h0001;
    bus(1'b1, `KP_OFF_DETECT, 32'h0F, 4'hF);
    bus(1'b1, `KP_OFF_CTRL, 32'h5, 4'hF);
    repeat (IVL - 8) @(posedge clk);
    rd32("no tick yet", `KP_OFF_STATUS, st_exp(8'h0F, ov, 8'h0F, 4'h0, 16'h1, 1'b0));
    repeat (8) @(posedge clk);
    rd32("tick", `KP_OFF_STATUS, st_exp(8'h0F, ov, 8'h0F, 4'h0, 16'h1, 1'b1));
    rd32("sample", `KP_OFF_SAMPLE, 32'h1);
    bus(1'b1, `KP_OFF_STATUS, 32'h1, 4'hF);
    rd32("tick clear", `KP_OFF_STATUS, st_exp(8'h0F, ov, 8'h0F, 4'h0, 16'h1, 1'b0));
    repeat (IVL - 10) @(posedge clk);
    rd32("next tick", `KP_OFF_STATUS, st_exp(8'h0F, ov, 8'h0F, 4'h0, 16'h1, 1'b1));
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule : keyport_top_tb_top

`default_nettype wire
